// [rtl/qhp_host.sv]
/*
 * host end of the quad channel parallel host port: an axi4-lite slave
 * whose command register runs one pin access in either bus style.
 * assumes device answers read data within the strobe phase.
 */
`timescale 1ns/1ps
`default_nettype none
`include "qhp_map.svh"

module qhp_host #(
	parameter int SETUP_CYC = `QHP_SETUP_CYC,
	parameter int STROBE_CYC = `QHP_STROBE_CYC,
	parameter int HOLD_CYC = `QHP_HOLD_CYC
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// axi4-lite slave
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// pins toward the device
	qhp_bus_if.host bus
);
	import qhp_pkg::*;

	qhp_host_s s_r;
	qhp_host_s s_nxt;
	logic [31:0] stat;
	logic [3:0] one_hot;

	////////////////////////////////////////////////////////////////////////
	// register slave and access sequencer

	always_comb begin
		s_nxt = s_r;
		one_hot = 4'h1 << s_r.chan;
		stat = 32'h0;
		stat[`QHP_STAT_RDATA_LSB +: 8] = s_r.rdata;
		stat[`QHP_STAT_BUSY_BIT] = (s_r.st != HS_IDLE);
		stat[`QHP_STAT_IRQ_LSB +: 4] = bus.channel_irq_out;
		stat[`QHP_STAT_TXN_LSB +: 4] = bus.channel_tx_ready_n;
		stat[`QHP_STAT_RXN_LSB +: 4] = bus.channel_rx_ready_n;
		stat[`QHP_STAT_CTXN_BIT] = bus.combined_tx_ready_n;
		stat[`QHP_STAT_CRXN_BIT] = bus.combined_rx_ready_n;

		// write path, address and data in either order
		if (s_axi_awvalid && s_r.awready) begin
			s_nxt.aw_got = 1'b1;
			s_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_r.wready) begin
			s_nxt.w_got = 1'b1;
			s_nxt.w_data = s_axi_wdata;
		end
		s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
		s_nxt.wready = !s_nxt.w_got && !s_nxt.bvalid;
		if (s_r.aw_got && s_r.w_got) begin
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = 2'h0;
			s_nxt.awready = 1'b0;
			s_nxt.wready = 1'b0;
			if (s_r.aw_addr[11:2] == `QHP_OFS_CTRL >> 2) begin
				if (s_axi_wstrb[0]) begin
					s_nxt.style = s_r.w_data[`QHP_CTRL_STYLE_BIT];
					s_nxt.force_en = s_r.w_data[`QHP_CTRL_FORCE_BIT];
				end
			end else if (s_r.aw_addr[11:2] == `QHP_OFS_CMD >> 2) begin
				// command while busy is dropped
				if (s_r.st == HS_IDLE) begin
					s_nxt.wdata = s_r.w_data[`QHP_CMD_DATA_LSB +: 8];
					s_nxt.addr = s_r.w_data[`QHP_CMD_ADDR_LSB +: 3];
					s_nxt.chan = s_r.w_data[`QHP_CMD_CHAN_LSB +: 2];
					s_nxt.wr = s_r.w_data[`QHP_CMD_WRITE_BIT];
					s_nxt.st = HS_SETUP;
					s_nxt.cnt = 4'(SETUP_CYC - 1);
				end
			end else if (s_r.aw_addr[11:2] != `QHP_OFS_STAT >> 2) begin
				s_nxt.bresp = 2'h2;
			end
		end
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
			s_nxt.awready = 1'b1;
			s_nxt.wready = 1'b1;
		end

		// read path
		s_nxt.arready = !s_r.rvalid && !(s_axi_arvalid && s_r.arready);
		if (s_axi_arvalid && s_r.arready) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = 2'h0;
			s_nxt.rdata_bus = 32'h0;
			if (s_axi_araddr[11:2] == `QHP_OFS_CTRL >> 2) begin
				s_nxt.rdata_bus[`QHP_CTRL_STYLE_BIT] = s_r.style;
				s_nxt.rdata_bus[`QHP_CTRL_FORCE_BIT] = s_r.force_en;
			end else if (s_axi_araddr[11:2] == `QHP_OFS_STAT >> 2) begin
				s_nxt.rdata_bus = stat;
			end else if (s_axi_araddr[11:2] != `QHP_OFS_CMD >> 2) begin
				s_nxt.rresp = 2'h2;
			end
		end else if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
			s_nxt.arready = 1'b1;
		end

		// pin access
		s_nxt.cs_n = 4'hF;
		s_nxt.rd_n = 1'b1;
		s_nxt.wr_n = s_r.style ? 1'b1 : !s_r.wr;
		s_nxt.d_oe = 1'b0;
		case (s_r.st)
			HS_IDLE: begin
				s_nxt.wr_n = 1'b1;
			end
			HS_SETUP: begin
				s_nxt.d_oe = s_r.wr;
				if (s_r.cnt == 4'h0) begin
					s_nxt.st = HS_STROBE;
					s_nxt.cnt = 4'(STROBE_CYC - 1);
				end else begin
					s_nxt.cnt = s_r.cnt - 4'h1;
				end
			end
			HS_STROBE: begin
				s_nxt.d_oe = s_r.wr;
				if (s_r.cnt == 4'h0) begin
					if (!s_r.wr) begin
						s_nxt.rdata = bus.d;
					end
					s_nxt.st = HS_HOLD;
					s_nxt.cnt = 4'(HOLD_CYC - 1);
				end else begin
					s_nxt.cnt = s_r.cnt - 4'h1;
					if (s_r.style) begin
						s_nxt.cs_n = ~one_hot;
						s_nxt.rd_n = s_r.wr;
						s_nxt.wr_n = !s_r.wr;
					end else begin
						s_nxt.cs_n = {1'b1, s_r.chan[1], s_r.chan[0], 1'b0};
					end
				end
			end
			HS_HOLD: begin
				s_nxt.d_oe = s_r.wr;
				if (s_r.cnt == 4'h0) begin
					s_nxt.st = HS_IDLE;
				end else begin
					s_nxt.cnt = s_r.cnt - 4'h1;
				end
			end
			default: begin
				s_nxt.st = HS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
			s_r.st <= HS_IDLE;
			{s_r.force_en, s_r.style} <= `QHP_CTRL_RESET;
			s_r.cs_n <= 4'hF;
			s_r.rd_n <= 1'b1;
			s_r.wr_n <= 1'b1;
			s_r.awready <= 1'b1;
			s_r.wready <= 1'b1;
			s_r.arready <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign s_axi_awready = s_r.awready;
	assign s_axi_wready = s_r.wready;
	assign s_axi_bvalid = s_r.bvalid;
	assign s_axi_bresp = s_r.bresp;
	assign s_axi_arready = s_r.arready;
	assign s_axi_rvalid = s_r.rvalid;
	assign s_axi_rdata = s_r.rdata_bus;
	assign s_axi_rresp = s_r.rresp;
	assign bus.bus_style = s_r.style;
	assign bus.irq_force_enable = s_r.style & s_r.force_en;
	assign bus.addr = s_r.addr;
	assign bus.read_strobe_n = s_r.rd_n;
	assign bus.write_strobe_n = s_r.wr_n;
	assign bus.channel_a_select_n = s_r.cs_n[0];
	assign bus.channel_b_select_n = s_r.cs_n[1];
	assign bus.channel_c_select_n = s_r.cs_n[2];
	assign bus.channel_d_select_n = s_r.cs_n[3];
	assign bus.host_d_o = s_r.wdata;
	assign bus.host_d_oe = s_r.d_oe;

endmodule : qhp_host

`default_nettype wire

// [rtl/qhp_map.svh]
/*
 * constants of the quad channel parallel host port: register offsets,
 * field positions, reset values and access timing counts.
 * assumes inclusion by bare name from the package, the host end, the pin interface and the bench.
 */
`ifndef QHP_MAP_SVH
`define QHP_MAP_SVH

// controller registers, one aligned 32-bit word each
`define QHP_OFS_CTRL 12'h000
`define QHP_OFS_CMD 12'h004
`define QHP_OFS_STAT 12'h008

// control fields
`define QHP_CTRL_STYLE_BIT 0
`define QHP_CTRL_FORCE_BIT 1
`define QHP_CTRL_RESET 2'h1

// command fields
`define QHP_CMD_DATA_LSB 0
`define QHP_CMD_ADDR_LSB 8
`define QHP_CMD_CHAN_LSB 11
`define QHP_CMD_WRITE_BIT 16

// status fields
`define QHP_STAT_RDATA_LSB 0
`define QHP_STAT_BUSY_BIT 8
`define QHP_STAT_IRQ_LSB 9
`define QHP_STAT_TXN_LSB 13
`define QHP_STAT_RXN_LSB 17
`define QHP_STAT_CTXN_BIT 21
`define QHP_STAT_CRXN_BIT 22

// access phase lengths in clk_sys cycles
`define QHP_SETUP_CYC 2
`define QHP_STROBE_CYC 4
`define QHP_HOLD_CYC 2

// level of an undriven data bus
`define QHP_BUS_PULL 8'hFF

`endif

// [rtl/qhp_pkg.sv]
/*
 * types of the quad channel parallel host port.
 * assumes qhp_map.svh on the include path.
 */
`include "qhp_map.svh"

package qhp_pkg;

	typedef enum logic [1:0] {DS_IDLE, DS_RD_REQ, DS_RD_DRV, DS_WR_ACT} qhp_dev_st_e;
	typedef enum logic [1:0] {HS_IDLE, HS_SETUP, HS_STROBE, HS_HOLD} qhp_host_st_e;
	typedef logic [7:0] qhp_byte_t;

	typedef struct packed {
		qhp_dev_st_e st;
		logic rd_act;
		logic wr_act;
		qhp_byte_t d_lat;
		logic reg_wr;
		logic reg_rd;
		logic [1:0] reg_chan;
		logic [2:0] reg_addr;
		qhp_byte_t reg_wdata;
		qhp_byte_t d_o;
		logic d_oe;
		logic [3:0] irq_o;
		logic [3:0] irq_oe;
		logic [3:0] tx_n;
		logic [3:0] rx_n;
		logic ctx_n;
		logic crx_n;
	} qhp_dev_s;

	typedef struct packed {
		qhp_host_st_e st;
		logic [3:0] cnt;
		logic style;
		logic force_en;
		logic wr;
		logic [1:0] chan;
		logic [2:0] addr;
		qhp_byte_t wdata;
		qhp_byte_t rdata;
		logic [3:0] cs_n;
		logic rd_n;
		logic wr_n;
		logic d_oe;
		logic aw_got;
		logic w_got;
		logic [11:0] aw_addr;
		logic [31:0] w_data;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata_bus;
		logic [1:0] rresp;
	} qhp_host_s;

endpackage : qhp_pkg

// [rtl/qhp_bus_if.sv]
/*
 * pins between the host processor end and the four channel device end.
 * assumes the bench joins both ends; undriven data reads as pull-up,
 * undriven interrupt pins read high on channel a and low elsewhere.
 */
`timescale 1ns/1ps
`default_nettype none
`include "qhp_map.svh"

interface qhp_bus_if;
	import qhp_pkg::*;

	// bus style strap and interrupt select, driven by the host side
	logic bus_style;
	logic irq_force_enable;
	// address, strobes, selects
	logic [2:0] addr;
	logic read_strobe_n;
	logic write_strobe_n;
	logic channel_a_select_n;
	logic channel_b_select_n;
	logic channel_c_select_n;
	logic channel_d_select_n;
	// data bus drivers and resolved level
	qhp_byte_t host_d_o;
	logic host_d_oe;
	qhp_byte_t dev_d_o;
	logic dev_d_oe;
	qhp_byte_t d;
	// interrupt pins, index 0 is channel a
	logic [3:0] channel_irq_o;
	logic [3:0] channel_irq_oe;
	logic [3:0] channel_irq_out;
	// ready outputs
	logic [3:0] channel_tx_ready_n;
	logic [3:0] channel_rx_ready_n;
	logic combined_tx_ready_n;
	logic combined_rx_ready_n;

	assign d = dev_d_oe ? dev_d_o : (host_d_oe ? host_d_o : `QHP_BUS_PULL);
	assign channel_irq_out = (channel_irq_oe & channel_irq_o) | (~channel_irq_oe & 4'h1);

	modport dev (
		input bus_style, irq_force_enable, addr, read_strobe_n, write_strobe_n,
		input channel_a_select_n, channel_b_select_n, channel_c_select_n, channel_d_select_n,
		input d,
		output dev_d_o, dev_d_oe, channel_irq_o, channel_irq_oe,
		output channel_tx_ready_n, channel_rx_ready_n, combined_tx_ready_n, combined_rx_ready_n
	);

	modport host (
		output bus_style, irq_force_enable, addr, read_strobe_n, write_strobe_n,
		output channel_a_select_n, channel_b_select_n, channel_c_select_n, channel_d_select_n,
		output host_d_o, host_d_oe,
		input d, channel_irq_out,
		input channel_tx_ready_n, channel_rx_ready_n, combined_tx_ready_n, combined_rx_ready_n
	);
endinterface : qhp_bus_if

`default_nettype wire

// [rtl/qhp_dev.sv]
/*
 * device end of the quad channel parallel host port: decodes both bus
 * styles into one register strobe per access, drives the data bus on
 * reads and the interrupt and ready pins of the four channels.
 * assumes pins synchronous to clk_sys and a register file on the user
 * side that presents read data while reg_rd_stb is high.
 */
// Overview of operation
// - eight bit two way data bus
// - three address lines pick channel register
// - strobe style: read strobe fall drives data
// - select style: read strobe ignored
// - strobe style: write strobe rise loads byte
// - select style: write strobe is direction line
// - strobe style: four selects, one channel each
// - select style: first select is device select
// - select style: selects b,c are channel bits
// - strobe style: modem control bit gates irq
// - select style: shared open drain irq low
// - select style: irq b-d held low
// - strobe style: force input enables irqs
// - host keeps force input low, select style
// - per channel tx ready, low active
// - per channel rx ready, low active
// - combined tx ready from any channel
// - combined rx ready from any channel
`timescale 1ns/1ps
`default_nettype none

module qhp_dev (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// pins toward the host
	qhp_bus_if.dev bus,
	// register strobes toward the channels
	output logic reg_wr_stb,
	output logic reg_rd_stb,
	output logic [1:0] reg_chan,
	output logic [2:0] reg_addr,
	output qhp_pkg::qhp_byte_t reg_wdata,
	input wire qhp_pkg::qhp_byte_t reg_rdata,
	// channel status
	input wire logic [3:0] chan_irq,
	input wire logic [3:0] chan_mcr3,
	input wire logic [3:0] chan_tx_ready,
	input wire logic [3:0] chan_rx_ready
);
	import qhp_pkg::*;

	qhp_dev_s s_r;
	qhp_dev_s s_nxt;
	logic strobe_style;
	logic sel_any;
	logic [1:0] sel_chan;
	logic rd_now;
	logic wr_now;
	logic irq_en_any;
	logic [3:0] irq_en;

	////////////////////////////////////////////////////////////////////////
	// access decode

	always_comb begin
		strobe_style = bus.bus_style;
		// one hot select, lowest channel wins on misuse
		sel_any = 1'b1;
		if (strobe_style) begin
			if (!bus.channel_a_select_n) begin
				sel_chan = 2'h0;
			end else if (!bus.channel_b_select_n) begin
				sel_chan = 2'h1;
			end else if (!bus.channel_c_select_n) begin
				sel_chan = 2'h2;
			end else if (!bus.channel_d_select_n) begin
				sel_chan = 2'h3;
			end else begin
				sel_chan = 2'h0;
				sel_any = 1'b0;
			end
			rd_now = sel_any && !bus.read_strobe_n;
			wr_now = sel_any && !bus.write_strobe_n;
		end else begin
			// fourth select unused here
			sel_chan = {bus.channel_c_select_n, bus.channel_b_select_n};
			sel_any = !bus.channel_a_select_n;
			// read strobe not looked at in this style
			rd_now = sel_any && bus.write_strobe_n;
			wr_now = sel_any && !bus.write_strobe_n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt pin enables

	always_comb begin
		irq_en = chan_mcr3 | {4{bus.irq_force_enable}};
		irq_en_any = |chan_irq;
	end

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		s_nxt = s_r;
		s_nxt.rd_act = rd_now;
		s_nxt.wr_act = wr_now;
		s_nxt.reg_wr = 1'b0;
		s_nxt.reg_rd = 1'b0;
		s_nxt.d_oe = 1'b0;
		case (s_r.st)
			DS_IDLE: begin
				if (rd_now && !s_r.rd_act) begin
					s_nxt.reg_chan = sel_chan;
					s_nxt.reg_addr = bus.addr;
					s_nxt.reg_rd = 1'b1;
					s_nxt.st = DS_RD_REQ;
				end else if (wr_now && !s_r.wr_act) begin
					s_nxt.reg_chan = sel_chan;
					s_nxt.reg_addr = bus.addr;
					s_nxt.d_lat = bus.d;
					s_nxt.st = DS_WR_ACT;
				end
			end
			DS_RD_REQ: begin
				s_nxt.d_o = reg_rdata;
				s_nxt.d_oe = rd_now;
				s_nxt.st = rd_now ? DS_RD_DRV : DS_IDLE;
			end
			DS_RD_DRV: begin
				s_nxt.d_oe = rd_now;
				if (!rd_now) begin
					s_nxt.st = DS_IDLE;
				end
			end
			DS_WR_ACT: begin
				if (wr_now) begin
					s_nxt.d_lat = bus.d;
				end else begin
					// byte as seen in the last cycle before the strobe rose
					s_nxt.reg_wdata = s_r.d_lat;
					s_nxt.reg_wr = 1'b1;
					s_nxt.st = DS_IDLE;
				end
			end
			default: begin
				s_nxt.st = DS_IDLE;
			end
		endcase

		// interrupt pins
		if (strobe_style) begin
			s_nxt.irq_o = chan_irq;
			s_nxt.irq_oe = irq_en;
		end else begin
			s_nxt.irq_o = 4'h0;
			s_nxt.irq_oe = {3'h7, irq_en_any};
		end

		// ready pins, also the dma requests
		s_nxt.tx_n = ~chan_tx_ready;
		s_nxt.rx_n = ~chan_rx_ready;
		s_nxt.ctx_n = ~|chan_tx_ready;
		s_nxt.crx_n = ~|chan_rx_ready;
	end

	////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_r.st <= DS_IDLE;
			s_r.rd_act <= 1'b0;
			s_r.wr_act <= 1'b0;
			s_r.d_lat <= 8'h00;
			s_r.reg_wr <= 1'b0;
			s_r.reg_rd <= 1'b0;
			s_r.reg_chan <= 2'h0;
			s_r.reg_addr <= 3'h0;
			s_r.reg_wdata <= 8'h00;
			s_r.d_o <= 8'h00;
			s_r.d_oe <= 1'b0;
			s_r.irq_o <= 4'h0;
			s_r.irq_oe <= 4'h0;
			s_r.tx_n <= 4'hF;
			s_r.rx_n <= 4'hF;
			s_r.ctx_n <= 1'b1;
			s_r.crx_n <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign reg_wr_stb = s_r.reg_wr;
	assign reg_rd_stb = s_r.reg_rd;
	assign reg_chan = s_r.reg_chan;
	assign reg_addr = s_r.reg_addr;
	assign reg_wdata = s_r.reg_wdata;
	assign bus.dev_d_o = s_r.d_o;
	assign bus.dev_d_oe = s_r.d_oe;
	assign bus.channel_irq_o = s_r.irq_o;
	assign bus.channel_irq_oe = s_r.irq_oe;
	assign bus.channel_tx_ready_n = s_r.tx_n;
	assign bus.channel_rx_ready_n = s_r.rx_n;
	assign bus.combined_tx_ready_n = s_r.ctx_n;
	assign bus.combined_rx_ready_n = s_r.crx_n;

endmodule : qhp_dev

`default_nettype wire

// [tb/qhp_checker.sv]
/*
 * pin level assertions between the host end and the device end.
 * assumes the bench instantiates it beside the joining interface.
 */
`timescale 1ns/1ps
`default_nettype none

module qhp_checker (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// host driven pins
	input wire logic bus_style,
	input wire logic irq_force_enable,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic channel_a_select_n,
	input wire logic channel_b_select_n,
	input wire logic channel_c_select_n,
	input wire logic channel_d_select_n,
	input wire logic host_d_oe,
	// device driven pins
	input wire logic dev_d_oe,
	input wire logic [3:0] channel_irq_o,
	input wire logic [3:0] channel_irq_oe,
	input wire logic [3:0] channel_tx_ready_n,
	input wire logic [3:0] channel_rx_ready_n,
	input wire logic combined_tx_ready_n,
	input wire logic combined_rx_ready_n
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	logic all_sel_n;
	logic idle;
	logic no_read;
	assign all_sel_n = &{channel_a_select_n, channel_b_select_n, channel_c_select_n,
		channel_d_select_n};
	assign idle = bus_style ? all_sel_n : channel_a_select_n;
	assign no_read = bus_style ? read_strobe_n : !write_strobe_n;

	////////////////////////////////////////////////////////////////////////////////
	sequence s_rd_strobe;
		bus_style && !read_strobe_n && !all_sel_n;
	endsequence
	sequence s_rd_select;
		!bus_style && write_strobe_n && !channel_a_select_n;
	endsequence
	sequence s_style0;
		!bus_style [*3];
	endsequence

	property p_no_clash;
		!(host_d_oe && dev_d_oe);
	endproperty
	a_no_clash: assert property (p_no_clash) else $error("data bus driven by both ends");
	property p_rd_strobe;
		s_rd_strobe [*3] |-> ##[0:1] dev_d_oe;
	endproperty
	a_rd_strobe: assert property (p_rd_strobe) else $error("strobe read not driven");
	property p_rd_select;
		s_rd_select [*3] |-> ##[0:1] dev_d_oe;
	endproperty
	a_rd_select: assert property (p_rd_select) else $error("select read not driven");
	property p_bus_release;
		idle [*4] |-> !dev_d_oe;
	endproperty
	a_bus_release: assert property (p_bus_release) else $error("bus kept when idle");
	property p_write_quiet;
		no_read [*4] |-> !dev_d_oe;
	endproperty
	a_write_quiet: assert property (p_write_quiet) else $error("bus driven on write");
	property p_shared_irq;
		s_style0 |-> !(channel_irq_oe[0] && channel_irq_o[0]);
	endproperty
	a_shared_irq: assert property (p_shared_irq) else $error("shared irq driven high");
	property p_spare_irq_low;
		s_style0 |-> channel_irq_oe[3:1] == 3'h7 && channel_irq_o[3:1] == 3'h0;
	endproperty
	a_spare_irq_low: assert property (p_spare_irq_low) else $error("spare irq not low");
	property p_force_irq;
		(bus_style && irq_force_enable) [*3] |-> channel_irq_oe == 4'hF;
	endproperty
	a_force_irq: assert property (p_force_irq) else $error("forced irq not enabled");
	property p_force_low;
		!bus_style |-> !irq_force_enable;
	endproperty
	a_force_low: assert property (p_force_low) else $error("force high in style 0");
	property p_ctx;
		$stable(channel_tx_ready_n) |-> combined_tx_ready_n == &channel_tx_ready_n;
	endproperty
	a_ctx: assert property (p_ctx) else $error("combined tx ready wrong");
	property p_crx;
		$stable(channel_rx_ready_n) |-> combined_rx_ready_n == &channel_rx_ready_n;
	endproperty
	a_crx: assert property (p_crx) else $error("combined rx ready wrong");
endmodule : qhp_checker

`default_nettype wire

// [tb/qhp_tb.sv]
/*
 * bench joining host and device ends, driving axi4-lite and channel side.
 * assumes the design files and qhp_map.svh on the include path.
 */
`timescale 1ns/1ps
`default_nettype none
`include "qhp_map.svh"

module qhp_tb;
	import qhp_pkg::*;
	logic clk_sys;
	logic rst_n;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, reg_wr_stb, reg_rd_stb;
	logic [1:0] reg_chan;
	logic [2:0] reg_addr;
	qhp_byte_t reg_wdata, reg_rdata;
	logic [3:0] chan_irq, chan_mcr3, chan_tx_ready, chan_rx_ready;
	logic [12:0] wr_log;
	int wr_cnt, rd_cnt, fail_count, cmp_count;

	qhp_bus_if bus ();
	qhp_host qhp_host_i (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bus(bus));
	qhp_dev qhp_dev_i (.clk_sys, .rst_n, .bus(bus), .reg_wr_stb, .reg_rd_stb, .reg_chan,
		.reg_addr, .reg_wdata, .reg_rdata, .chan_irq, .chan_mcr3, .chan_tx_ready, .chan_rx_ready);
	qhp_checker qhp_checker_i (.clk_sys, .rst_n, .bus_style(bus.bus_style),
		.irq_force_enable(bus.irq_force_enable), .read_strobe_n(bus.read_strobe_n),
		.write_strobe_n(bus.write_strobe_n), .channel_a_select_n(bus.channel_a_select_n),
		.channel_b_select_n(bus.channel_b_select_n), .channel_c_select_n(bus.channel_c_select_n),
		.channel_d_select_n(bus.channel_d_select_n), .host_d_oe(bus.host_d_oe),
		.dev_d_oe(bus.dev_d_oe), .channel_irq_o(bus.channel_irq_o),
		.channel_irq_oe(bus.channel_irq_oe), .channel_tx_ready_n(bus.channel_tx_ready_n),
		.channel_rx_ready_n(bus.channel_rx_ready_n), .combined_tx_ready_n(bus.combined_tx_ready_n),
		.combined_rx_ready_n(bus.combined_rx_ready_n));

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	// channel register file: read byte while the read strobe stands, write log
	always_comb reg_rdata = reg_rd_stb ? {3'h5, reg_chan, reg_addr} : 8'h00;
	always @(posedge clk_sys) begin
		if (reg_rd_stb === 1'b1) begin
			rd_cnt <= rd_cnt + 1;
		end
		if (reg_wr_stb === 1'b1) begin
			wr_log <= {reg_chan, reg_addr, reg_wdata};
			wr_cnt <= wr_cnt + 1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t word %h expected %h", $time, got, exp);
		end
	endtask : chk_word
	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t resp %h expected %h", $time, got, exp);
		end
	endtask : chk_resp
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (!aw_ok && s_axi_awready === 1'b1) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_ok && s_axi_wready === 1'b1) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end while (!(aw_ok && w_ok));
		while (s_axi_bvalid !== 1'b1) @(posedge clk_sys);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge clk_sys);
	endtask : axi_wr
	task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge clk_sys);
	endtask : axi_rd
	// one pin access through the command register, then wait until idle
	task automatic pin_acc(input logic wr, input logic [1:0] ch, input logic [2:0] ad,
		input logic [7:0] wd);
		axi_wr(`QHP_OFS_CMD, {15'h0, wr, 3'h0, ch, ad, wd}, rsp);
		rd = 32'h100;
		while (rd[8] !== 1'b0) axi_rd(`QHP_OFS_STAT, rd, rsp);
	endtask : pin_acc
	task automatic stat_case(input logic [1:0] ctl, input logic [3:0] irq, input logic [3:0] m3,
		input logic [3:0] tx, input logic [3:0] rx, input logic [3:0] exp_irq);
		axi_wr(`QHP_OFS_CTRL, {30'h0, ctl}, rsp);
		chan_irq <= irq;
		chan_mcr3 <= m3;
		chan_tx_ready <= tx;
		chan_rx_ready <= rx;
		repeat (4) @(posedge clk_sys);
		chk_word({31'h0, bus.irq_force_enable}, {31'h0, ctl[0] & ctl[1]});
		axi_rd(`QHP_OFS_STAT, rd, rsp);
		chk_word({18'h0, rd[22:9]}, {18'h0, ~|rx, ~|tx, ~rx, ~tx, exp_irq});
	endtask : stat_case
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : final_report

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#50us;
		fail_count++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		final_report();
	end
	initial begin
		{rst_n, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{chan_irq, chan_mcr3, chan_tx_ready, chan_rx_ready} = '0;
		wr_cnt = 0;
		rd_cnt = 0;
		fail_count = 0;
		cmp_count = 0;
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		axi_rd(`QHP_OFS_CTRL, rd, rsp);
		chk_word(rd, 32'h1);
		axi_rd(12'h00C, rd, rsp);
		chk_resp(rsp, 2'h2);
		axi_wr(12'h010, 32'h0, rsp);
		chk_resp(rsp, 2'h2);
		// reads and writes on every channel, both bus styles
		for (int s = 1; s >= 0; s--) begin
			axi_wr(`QHP_OFS_CTRL, 32'(s), rsp);
			for (int c = 0; c < 4; c++) begin
				pin_acc(1'b0, 2'(c), 3'(7 - c), 8'h00);
				chk_word({24'h0, rd[7:0]}, {24'h0, 3'h5, 2'(c), 3'(7 - c)});
				pin_acc(1'b1, 2'(c), 3'(c), 8'h3C + 8'(c));
				chk_word(32'(wr_log), {19'h0, 2'(c), 3'(c), 8'h3C + 8'(c)});
			end
		end
		chk_word(32'(wr_cnt), 32'd8);
		chk_word(32'(rd_cnt), 32'h8);
		// interrupt and ready pins in both styles
		stat_case(2'h0, 4'h5, 4'h0, 4'h6, 4'h0, 4'h0);
		stat_case(2'h2, 4'h0, 4'hF, 4'h0, 4'h9, 4'h1);
		stat_case(2'h1, 4'h5, 4'h0, 4'hF, 4'h1, 4'h1);
		stat_case(2'h1, 4'hA, 4'hF, 4'h8, 4'hF, 4'hA);
		stat_case(2'h3, 4'h6, 4'h0, 4'h0, 4'h0, 4'h6);
		final_report();
	end
endmodule : qhp_tb

`default_nettype wire
